// file: logic/ppm_pkg.sv
// Package for the port power management register bank.
// Assumes a 40 MHz core clock and a config-space style word access port.
package ppm_pkg;

  // ************************************************************
  // Register offsets and field positions
  // ************************************************************
  localparam logic [11:0] PPM_OFF_CTRL_STATUS = 12'h074;
  localparam logic [11:0] PPM_OFF_TIMER_CTRL  = 12'h078;
  localparam int          PPM_BIT_WAKE_EN     = 8;
  localparam int          PPM_BIT_WAKE_STS    = 15;
  localparam int          PPM_BIT_LAYOUT      = 31;
  localparam int          PPM_LO_LIGHT        = 16;

  // ************************************************************
  // Values after reset and codes
  // ************************************************************
  localparam logic [1:0]  PPM_POWER_STATE_CODE_D0       = 2'h0;
  localparam logic [1:0]  PPM_POWER_STATE_CODE_D3HOT    = 2'h3;
  localparam logic [15:0] PPM_DEEP_RESET      = 16'h03E8;
  localparam logic [11:0] PPM_LIGHT_RESET     = 12'h6D6;
  localparam logic [5:0]  PPM_LINK_L0         = 6'h00;
  localparam logic [5:0]  PPM_LINK_L1         = 6'h1A;

  // ************************************************************
  // Tick timing
  // ************************************************************
  localparam int          PPM_CLK_MHZ         = 40;
  localparam int          PPM_CLK_PERIOD_NS   = 25;
  localparam int          PPM_US_TICK_US      = 1;
  localparam int          PPM_NS_TICK_NS      = 4;
  localparam int          PPM_US_TICK_CYC     = PPM_US_TICK_US * PPM_CLK_MHZ;
  // A 4 ns tick is shorter than one clock; it rounds up to one cycle.
  localparam int          PPM_NS_TICK_CYC     =
    (PPM_NS_TICK_NS + PPM_CLK_PERIOD_NS - 1) / PPM_CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ppm_req_t;

  typedef enum logic [2:0] {
    PPM_LS_ACTIVE = 3'b001,
    PPM_LS_LIGHT  = 3'b010,
    PPM_LS_DEEP   = 3'b100
  } ppm_lstate_t;

endpackage

// file: logic/ppm_ctrl.sv
// Port power management control, status and idle entry timers.
// Assumes config requests and link conditions come from core-clock logic.
`timescale 1ns/1ps
module ppm_ctrl #(
  parameter bit PORT_A = 1'b0                 // Status bit not implemented on port A
) (
  input  wire logic            i_core_clk,    // Core clock, 40 MHz
  input  wire logic            i_srst,        // Fundamental reset, sync high
  input  wire logic            i_hot_rst,     // Hot reset, sync high
  input  wire ppm_pkg::ppm_req_t i_req,       // Config read or write request
  input  wire logic            i_upstream,    // Port is upstream
  input  wire logic            i_own_wake,    // Port itself raised a wake event
  input  wire logic            i_fwd_wake,    // Forwarded wake message seen
  input  wire logic            i_light_cond,  // Light idle entry conditions met
  input  wire logic            i_deep_cond,   // Deep idle entry conditions met
  input  wire logic            i_link_busy,   // Link must leave idle
  output logic [31:0]          o_rdata,       // Read data
  output logic                 o_rvalid,      // Read data valid pulse
  output logic [1:0]           o_power_state_code, // Current power state
  output logic                 o_wake_msg,    // Wake message request pulse
  output logic                 o_light_idle,  // Transmitter in light idle
  output logic                 o_deep_idle,   // Transmitter in deep idle
  output logic [5:0]           o_link_pm_state // Link power state code
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [1:0]  power_state_code_q,     power_state_code_d;
  logic        wake_en_q,    wake_en_d;
  logic        wake_sts_q,   wake_sts_d;
  logic [15:0] deep_tmr_q,   deep_tmr_d;
  logic [11:0] light_tmr_q,  light_tmr_d;
  logic        layout_q,     layout_d;
  logic [31:0] rdata_q,      rdata_d;
  logic        rvalid_q,     rvalid_d;
  logic        wake_msg_q,   wake_msg_d;
  logic        wr_cs, wr_tc;

  always_comb begin
    wr_cs      = i_req.wr && (i_req.addr == ppm_pkg::PPM_OFF_CTRL_STATUS);
    wr_tc      = i_req.wr && (i_req.addr == ppm_pkg::PPM_OFF_TIMER_CTRL);
    power_state_code_d   = power_state_code_q;
    wake_en_d  = wake_en_q;
    wake_sts_d = wake_sts_q;
    deep_tmr_d = deep_tmr_q;
    light_tmr_d = light_tmr_q;
    layout_d   = layout_q;
    if (wr_cs && ((i_req.wdata[1:0] == ppm_pkg::PPM_POWER_STATE_CODE_D0) ||
                  (i_req.wdata[1:0] == ppm_pkg::PPM_POWER_STATE_CODE_D3HOT))) begin
      power_state_code_d = i_req.wdata[1:0];
    end
    if (wr_cs) begin
      wake_en_d = i_req.wdata[ppm_pkg::PPM_BIT_WAKE_EN];
    end
    if (wr_cs && i_req.wdata[ppm_pkg::PPM_BIT_WAKE_STS]) begin
      wake_sts_d = 1'b0;
    end
    if (i_own_wake) begin
      wake_sts_d = 1'b1;
    end
    if (PORT_A) begin
      wake_sts_d = 1'b0;
    end
    if (wr_tc) begin
      layout_d = i_req.wdata[ppm_pkg::PPM_BIT_LAYOUT];
      if (!i_req.wdata[ppm_pkg::PPM_BIT_LAYOUT]) begin
        deep_tmr_d  = i_req.wdata[15:0];
        light_tmr_d = i_req.wdata[ppm_pkg::PPM_LO_LIGHT +: 12];
      end
    end
    wake_msg_d = i_own_wake && wake_en_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wake_en_q  <= 1'b0;
      wake_sts_q <= 1'b0;
    end else begin
      wake_en_q  <= wake_en_d;
      wake_sts_q <= wake_sts_d;
    end
    if (i_srst || i_hot_rst) begin
      power_state_code_q    <= ppm_pkg::PPM_POWER_STATE_CODE_D0;
      deep_tmr_q  <= ppm_pkg::PPM_DEEP_RESET;
      light_tmr_q <= ppm_pkg::PPM_LIGHT_RESET;
      layout_q    <= 1'b0;
      wake_msg_q  <= 1'b0;
    end else begin
      power_state_code_q    <= power_state_code_d;
      deep_tmr_q  <= deep_tmr_d;
      light_tmr_q <= light_tmr_d;
      layout_q    <= layout_d;
      wake_msg_q  <= wake_msg_d;
    end
  end

  // ************************************************************
  // Tick generators
  // ************************************************************
  logic [5:0] us_cnt_q, us_cnt_d;
  logic [1:0] ns_cnt_q, ns_cnt_d;
  logic       us_tick, ns_tick;

  always_comb begin
    us_tick  = (us_cnt_q == 6'(ppm_pkg::PPM_US_TICK_CYC - 1));
    ns_tick  = (ns_cnt_q == 2'(ppm_pkg::PPM_NS_TICK_CYC - 1));
    us_cnt_d = us_tick ? 6'h00 : us_cnt_q + 6'h01;
    ns_cnt_d = ns_tick ? 2'h0 : ns_cnt_q + 2'h1;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      us_cnt_q <= 6'h00;
      ns_cnt_q <= 2'h0;
    end else begin
      us_cnt_q <= us_cnt_d;
      ns_cnt_q <= ns_cnt_d;
    end
  end

  // ************************************************************
  // Idle entry timers and link power state
  // ************************************************************
  ppm_pkg::ppm_lstate_t st_q, st_d;
  logic [15:0] deep_cnt_q,  deep_cnt_d;
  logic [11:0] light_cnt_q, light_cnt_d;
  logic        deep_ok, light_ok;
  logic        light_idle_q, light_idle_d, deep_idle_q, deep_idle_d;

  always_comb begin
    deep_ok  = i_deep_cond && i_upstream;
    light_ok = i_light_cond;
    deep_cnt_d  = !deep_ok ? 16'h0000 :
                  (us_tick && deep_cnt_q != 16'hFFFF) ? deep_cnt_q + 16'h0001 : deep_cnt_q;
    light_cnt_d = !light_ok ? 12'h000 :
                  (ns_tick && light_cnt_q != 12'hFFF) ? light_cnt_q + 12'h001 : light_cnt_q;
    st_d = st_q;
    case (st_q)
      ppm_pkg::PPM_LS_ACTIVE: begin
        if (deep_ok && deep_cnt_q >= deep_tmr_q) begin
          st_d = ppm_pkg::PPM_LS_DEEP;
        end else if (light_ok && light_cnt_q >= light_tmr_q) begin
          st_d = ppm_pkg::PPM_LS_LIGHT;
        end
      end
      ppm_pkg::PPM_LS_LIGHT: begin
        if (i_link_busy) begin
          st_d = ppm_pkg::PPM_LS_ACTIVE;
        end else if (deep_ok && deep_cnt_q >= deep_tmr_q) begin
          st_d = ppm_pkg::PPM_LS_DEEP;
        end
      end
      ppm_pkg::PPM_LS_DEEP: begin
        if (i_link_busy) begin
          st_d = ppm_pkg::PPM_LS_ACTIVE;
        end
      end
      default: st_d = ppm_pkg::PPM_LS_ACTIVE;
    endcase
    light_idle_d = (st_d == ppm_pkg::PPM_LS_LIGHT);
    deep_idle_d  = (st_d == ppm_pkg::PPM_LS_DEEP);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_hot_rst) begin
      st_q        <= ppm_pkg::PPM_LS_ACTIVE;
      deep_cnt_q  <= 16'h0000;
      light_cnt_q <= 12'h000;
      light_idle_q <= 1'b0;
      deep_idle_q  <= 1'b0;
    end else begin
      st_q        <= st_d;
      deep_cnt_q  <= deep_cnt_d;
      light_cnt_q <= light_cnt_d;
      light_idle_q <= light_idle_d;
      deep_idle_q  <= deep_idle_d;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [5:0] lcode;

  always_comb begin
    lcode = (st_q == ppm_pkg::PPM_LS_DEEP) ? ppm_pkg::PPM_LINK_L1 : ppm_pkg::PPM_LINK_L0;
    rdata_d  = 32'h0000_0000;
    rvalid_d = i_req.rd;
    if (i_req.rd && (i_req.addr == ppm_pkg::PPM_OFF_CTRL_STATUS)) begin
      rdata_d[1:0] = power_state_code_q;
      rdata_d[ppm_pkg::PPM_BIT_WAKE_EN]  = wake_en_q;
      rdata_d[ppm_pkg::PPM_BIT_WAKE_STS] = wake_sts_q;
    end else if (i_req.rd && (i_req.addr == ppm_pkg::PPM_OFF_TIMER_CTRL)) begin
      rdata_d[ppm_pkg::PPM_BIT_LAYOUT] = layout_q;
      if (layout_q) begin
        rdata_d[5:0] = lcode;
      end else begin
        rdata_d[15:0]  = deep_tmr_q;
        rdata_d[ppm_pkg::PPM_LO_LIGHT +: 12] = light_tmr_q;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  logic [5:0] lcode_q;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      lcode_q <= ppm_pkg::PPM_LINK_L0;
    end else begin
      lcode_q <= lcode;
    end
  end

  assign o_rdata            = rdata_q;
  assign o_rvalid           = rvalid_q;
  assign o_power_state_code = power_state_code_q;
  assign o_wake_msg         = wake_msg_q;
  assign o_light_idle       = light_idle_q;
  assign o_deep_idle        = deep_idle_q;
  assign o_link_pm_state    = lcode_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_power_state_code_legal;
    @(posedge i_core_clk) disable iff (i_srst)
      (power_state_code_q != 2'h1) && (power_state_code_q != 2'h2);
  endproperty
  a_power_state_code_legal: assert property (p_power_state_code_legal) else $error("reserved power state held");

  property p_power_state_code_wr;
    @(posedge i_core_clk) disable iff (i_srst || i_hot_rst)
      wr_cs && i_req.wdata[1:0] == 2'h3 |=> power_state_code_q == 2'h3;
  endproperty
  a_power_state_code_wr: assert property (p_power_state_code_wr) else $error("power state write lost");

  property p_wake_gate;
    @(posedge i_core_clk) disable iff (i_srst || i_hot_rst)
      o_wake_msg |-> $past(wake_en_q) && $past(i_own_wake);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake message while disabled");

  property p_en_hot;
    @(posedge i_core_clk) disable iff (i_srst)
      i_hot_rst && !wr_cs |=> wake_en_q == $past(wake_en_q);
  endproperty
  a_en_hot: assert property (p_en_hot) else $error("hot reset changed enable");

  property p_sts_set;
    @(posedge i_core_clk) disable iff (i_srst)
      i_own_wake && !PORT_A |=> wake_sts_q;
  endproperty
  a_sts_set: assert property (p_sts_set) else $error("status not set");

  property p_fwd;
    @(posedge i_core_clk) disable iff (i_srst)
      !i_own_wake && !wr_cs |=> wake_sts_q == $past(wake_sts_q);
  endproperty
  a_fwd: assert property (p_fwd) else $error("status changed without own event");

  property p_fwd_keep;
    @(posedge i_core_clk) disable iff (i_srst)
      i_fwd_wake && !i_own_wake && !wr_cs |=> $stable(wake_sts_q);
  endproperty
  a_fwd_keep: assert property (p_fwd_keep) else $error("forwarded wake set status");

  property p_zero;
    @(posedge i_core_clk) disable iff (i_srst)
      i_req.rd && i_req.addr == ppm_pkg::PPM_OFF_CTRL_STATUS |=>
        o_rvalid && o_rdata[31:16] == 16'h0000 && o_rdata[14:9] == 6'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("fixed-zero fields nonzero");

  property p_down;
    @(posedge i_core_clk) disable iff (i_srst || i_hot_rst)
      !i_upstream && !o_deep_idle |=> !o_deep_idle;
  endproperty
  a_down: assert property (p_down) else $error("downstream entered deep idle");

  property p_restart;
    @(posedge i_core_clk) disable iff (i_srst || i_hot_rst)
      !i_light_cond |=> light_cnt_q == 12'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("light timer not restarted");

  property p_readback;
    @(posedge i_core_clk) disable iff (i_srst)
      i_req.rd && layout_q && i_req.addr == ppm_pkg::PPM_OFF_TIMER_CTRL |=>
        o_rdata[5:0] == (($past(st_q) == ppm_pkg::PPM_LS_DEEP) ? 6'h1A : 6'h00);
  endproperty
  a_readback: assert property (p_readback) else $error("readback code wrong");

endmodule

// file: testbench/ppm_host_model.sv
// Host software model that issues config reads and writes to the bank.
// Assumes read data arrives one cycle after the read request.
`timescale 1ns/1ps
module ppm_host_model (
  input  wire logic         i_core_clk, // Core clock
  input  wire logic [31:0]  i_rdata,    // Read data from the bank
  input  wire logic         i_rvalid,   // Read data valid pulse
  output ppm_pkg::ppm_req_t o_req       // Request to the bank
);
  initial begin
    o_req = '0;
  end

  // ************************************************************
  // Config cycles
  // ************************************************************
  task automatic cfg_write(input logic [11:0] addr, input logic [31:0] data);
    @(posedge i_core_clk);
    #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge i_core_clk);
    #1;
    o_req = '0;
  endtask

  task automatic cfg_read(input logic [11:0] addr, output logic [31:0] data,
                          output logic ok);
    @(posedge i_core_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h00000000};
    @(posedge i_core_clk);
    #1;
    o_req = '0;
    data  = i_rdata;
    ok    = i_rvalid;
  endtask

  task automatic init_wake();
    cfg_write(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00000100);
  endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the port power management register bank.
// Assumes the host model drives requests; link conditions come from here.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic [1:0]  ps;
  } ppm_row_t;

  logic clk, srst, hot_rst, upstream, own_wake, fwd_wake;
  logic light_cond, deep_cond, link_busy, rvalid, wake_msg, light_idle, deep_idle;
  logic [31:0] rdata, rdata_a;
  logic [1:0]  power_state_code;
  logic [5:0]  link_state;
  ppm_pkg::ppm_req_t req;
  int n_errors;
  int num_checks;
  ppm_row_t rows [9] = '{
    '{1'b0, 12'h074, 32'h00000000, 32'h00000000, 2'h0},
    '{1'b0, 12'h078, 32'h00000000, 32'h06D603E8, 2'h0},
    '{1'b1, 12'h074, 32'hFFFFFFFF, 32'h00000103, 2'h3},
    '{1'b1, 12'h074, 32'h00000001, 32'h00000003, 2'h3},
    '{1'b1, 12'h074, 32'h00000002, 32'h00000003, 2'h3},
    '{1'b1, 12'h074, 32'h00000000, 32'h00000000, 2'h0},
    '{1'b1, 12'h07C, 32'hFFFFFFFF, 32'h00000000, 2'h0},
    '{1'b1, 12'h078, 32'h70050002, 32'h00050002, 2'h0},
    '{1'b1, 12'h074, 32'h00000100, 32'h00000100, 2'h0}};

  ppm_ctrl u_ppm_ctrl (
    .i_core_clk(clk), .i_srst(srst), .i_hot_rst(hot_rst), .i_req(req),
    .i_upstream(upstream), .i_own_wake(own_wake), .i_fwd_wake(fwd_wake),
    .i_light_cond(light_cond), .i_deep_cond(deep_cond), .i_link_busy(link_busy),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_power_state_code(power_state_code),
    .o_wake_msg(wake_msg), .o_light_idle(light_idle), .o_deep_idle(deep_idle),
    .o_link_pm_state(link_state));

  ppm_host_model u_ppm_host_model (
    .i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  // Port A copy on the same request bus; its wake status must read zero.
  ppm_ctrl #(.PORT_A(1'b1)) u_ppm_ctrl_a (
    .i_core_clk(clk), .i_srst(srst), .i_hot_rst(hot_rst), .i_req(req),
    .i_upstream(upstream), .i_own_wake(own_wake), .i_fwd_wake(fwd_wake),
    .i_light_cond(light_cond), .i_deep_cond(deep_cond), .i_link_busy(link_busy),
    .o_rdata(rdata_a), .o_rvalid(), .o_power_state_code(),
    .o_wake_msg(), .o_light_idle(), .o_deep_idle(), .o_link_pm_state());

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %b seen %b", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    u_ppm_host_model.cfg_read(addr, d, ok);
    cmp_bit("rvalid", 1'b1, ok);
    cmp_word("rdata", exp, d);
  endtask

  task automatic wake_pulse(input logic own, input logic exp_msg);
    own_wake = own;
    fwd_wake = !own;
    tick(1);
    own_wake = 1'b0;
    fwd_wake = 1'b0;
    cmp_bit("wake_msg", exp_msg, wake_msg);
  endtask

  task automatic leave_idle();
    light_cond = 1'b0;
    deep_cond  = 1'b0;
    link_busy  = 1'b1;
    tick(1);
    link_busy  = 1'b0;
    tick(1);
  endtask

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 5000);
    n_errors++;
    stop_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {hot_rst, upstream, own_wake, fwd_wake, light_cond, deep_cond, link_busy} = '0;
    srst = 1'b1;
    tick(8);
    srst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) u_ppm_host_model.cfg_write(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
      cmp_word("power_state_code", {30'h0, rows[i].ps}, {30'h0, power_state_code});
    end
    light_cond = 1'b1;
    tick(3);
    cmp_bit("light_idle", 1'b0, light_idle);
    tick(5);
    cmp_bit("light_idle", 1'b1, light_idle);
    cmp_word("pm_state", 32'h00000000, {26'h0, link_state});
    leave_idle();
    light_cond = 1'b1;
    tick(3);
    light_cond = 1'b0;
    tick(1);
    light_cond = 1'b1;
    tick(3);
    cmp_bit("light_idle", 1'b0, light_idle);
    tick(5);
    cmp_bit("light_idle", 1'b1, light_idle);
    leave_idle();
    deep_cond = 1'b1;
    tick(125);
    cmp_bit("deep_idle", 1'b0, deep_idle);
    deep_cond = 1'b0;
    tick(1);
    upstream  = 1'b1;
    deep_cond = 1'b1;
    tick(30);
    cmp_bit("deep_idle", 1'b0, deep_idle);
    tick(95);
    cmp_bit("deep_idle", 1'b1, deep_idle);
    cmp_word("pm_state", 32'h0000001A, {26'h0, link_state});
    u_ppm_host_model.cfg_write(ppm_pkg::PPM_OFF_TIMER_CTRL, 32'h80000000);
    rd_chk(ppm_pkg::PPM_OFF_TIMER_CTRL, 32'h8000001A);
    leave_idle();
    u_ppm_host_model.cfg_write(ppm_pkg::PPM_OFF_TIMER_CTRL, 32'h00050002);
    rd_chk(ppm_pkg::PPM_OFF_TIMER_CTRL, 32'h00050002);
    wake_pulse(1'b1, 1'b1);
    rd_chk(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00008100);
    cmp_word("rdata_a", 32'h00000100, rdata_a);
    u_ppm_host_model.cfg_write(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00008100);
    rd_chk(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00000100);
    wake_pulse(1'b0, 1'b0);
    rd_chk(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00000100);
    u_ppm_host_model.cfg_write(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00000000);
    wake_pulse(1'b1, 1'b0);
    rd_chk(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00008000);
    cmp_word("rdata_a", 32'h00000000, rdata_a);
    u_ppm_host_model.init_wake();
    u_ppm_host_model.cfg_write(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00000103);
    hot_rst = 1'b1;
    tick(1);
    hot_rst = 1'b0;
    rd_chk(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00008100);
    cmp_word("power_state_code", 32'h00000000, {30'h0, power_state_code});
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    rd_chk(ppm_pkg::PPM_OFF_CTRL_STATUS, 32'h00000000);
    rd_chk(ppm_pkg::PPM_OFF_TIMER_CTRL, 32'h06D603E8);
    stop_test();
  end
endmodule
